// >>> cmc_pkg.sv
// Constants, types and mode decoding for the comparator mode control block
package cmc_pkg;

   // ----------------------------------------------------------------
   // Widths and pin indices
   // ----------------------------------------------------------------
   localparam int unsigned CMC_NPINS   = 3;
   localparam int unsigned CMC_PIN_INV = 0;  // Inverting input pin
   localparam int unsigned CMC_PIN_NON = 1;  // Non-inverting input pin
   localparam int unsigned CMC_PIN_OUT = 2;  // External result pin

   // ----------------------------------------------------------------
   // Configuration register layout
   // ----------------------------------------------------------------
   localparam int unsigned CMC_MODE_LSB   = 0;
   localparam int unsigned CMC_MODE_MSB   = 2;
   localparam int unsigned CMC_SWITCH_BIT = 3;
   localparam int unsigned CMC_INVERT_BIT = 4;
   localparam int unsigned CMC_RESULT_BIT = 6;
   localparam logic [7:0]  CMC_CFG_RESET  = 8'h00;
   localparam logic        CMC_BIT_RESET  = 1'h0;

   // ----------------------------------------------------------------
   // Mode selection codes
   // ----------------------------------------------------------------
   localparam logic [2:0] CMC_MODE_RESET   = 3'h0;
   localparam logic [2:0] CMC_MODE_OUT     = 3'h1;
   localparam logic [2:0] CMC_MODE_NOOUT   = 3'h2;
   localparam logic [2:0] CMC_MODE_REF_OUT = 3'h3;
   localparam logic [2:0] CMC_MODE_REF     = 3'h4;
   localparam logic [2:0] CMC_MODE_MUX_OUT = 3'h5;
   localparam logic [2:0] CMC_MODE_MUX     = 3'h6;
   localparam logic [2:0] CMC_MODE_OFF     = 3'h7;

   // Pin and core setup derived from one mode code
   typedef struct packed {
      logic [2:0] analog;     // Digital input buffer off, reads 0
      logic [2:0] drive_cmp;  // Pin carries the result
      logic       enable;     // Comparator powered
      logic       use_ref;    // Internal reference on non-inverting input
      logic       mux;        // Input switch active
   } cmc_mode_cfg_t;

   // Decode a mode code into its pin functions
   function automatic cmc_mode_cfg_t cmc_decode(input logic [2:0] mode);
      cmc_mode_cfg_t c;
      c = '0;
      case (mode)
         CMC_MODE_RESET:   c = '{3'h3, 3'h0, 1'b0, 1'b0, 1'b0};
         CMC_MODE_OUT:     c = '{3'h3, 3'h4, 1'b1, 1'b0, 1'b0};
         CMC_MODE_NOOUT:   c = '{3'h3, 3'h0, 1'b1, 1'b0, 1'b0};
         CMC_MODE_REF_OUT: c = '{3'h1, 3'h4, 1'b1, 1'b1, 1'b0};
         CMC_MODE_REF:     c = '{3'h1, 3'h0, 1'b1, 1'b1, 1'b0};
         CMC_MODE_MUX_OUT: c = '{3'h3, 3'h4, 1'b1, 1'b1, 1'b1};
         CMC_MODE_MUX:     c = '{3'h3, 3'h0, 1'b1, 1'b1, 1'b1};
         CMC_MODE_OFF:     c = '{3'h0, 3'h0, 1'b0, 1'b0, 1'b0};
         default:          c = '{3'h3, 3'h0, 1'b0, 1'b0, 1'b0};
      endcase
      return c;
   endfunction : cmc_decode

endpackage : cmc_pkg

// >>> cmc_pin_if.sv
// Interface carrying pin functions from the control core to the pin logic
`timescale 1ns/10ps
interface cmc_pin_if;
   logic [2:0] analog;     // Pin in analog function
   logic [2:0] drive_cmp;  // Pin carries the comparator result
   logic       cmp_value;  // Result after polarity
   logic [2:0] port_out;   // Port latch output data
   logic [2:0] port_dir;   // Direction bits, 1 = input

   modport ctrl (output analog, output drive_cmp, output cmp_value,
                 output port_out, output port_dir);
   modport pins (input analog, input drive_cmp, input cmp_value,
                 input port_out, input port_dir);
endinterface : cmc_pin_if

// >>> cmc_sync.sv
// Two-stage synchroniser for the asynchronous comparator result
`timescale 1ns/10ps
module cmc_sync (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic async_in,
   output logic      sync_out
);
   import cmc_pkg::*;

   typedef struct packed {
      logic stage1;
      logic stage2;
   } cmc_sync_t;

   cmc_sync_t state_ff;
   cmc_sync_t nxt_state;

   // Stage one feeds only stage two
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.stage1 = async_in;
      nxt_state.stage2 = state_ff.stage1;
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sync_out = state_ff.stage2;
endmodule : cmc_sync

// >>> cmc_pin_mux.sv
// Per-pin port logic: analog masking, result override and read-back
`timescale 1ns/10ps
module cmc_pin_mux (
   input  wire logic       clock,
   input  wire logic       nrst,
   cmc_pin_if.pins         pin_cfg,
   input  wire logic [2:0] pin_in,
   output logic      [2:0] pin_out,
   output logic      [2:0] pin_oe,
   output logic      [2:0] pin_in_buf_en,
   output logic      [2:0] port_rd_data
);
   import cmc_pkg::*;

   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe;
      logic [2:0] buf_en;
      logic [2:0] rd;
   } cmc_pin_t;

   cmc_pin_t state_ff;
   cmc_pin_t nxt_state;

   // Pin function per pin
   always_comb begin
      nxt_state = state_ff;
      for (int i = 0; i < CMC_NPINS; i++) begin
         // Result overrides the port latch
         nxt_state.out[i]    = pin_cfg.drive_cmp[i] ? pin_cfg.cmp_value
                                                    : pin_cfg.port_out[i]; // see RULE4
         nxt_state.oe[i]     = ~pin_cfg.port_dir[i];
         // Analog pins lose the input buffer and read zero
         nxt_state.buf_en[i] = ~pin_cfg.analog[i];                        // see RULE3
         nxt_state.rd[i]     = pin_cfg.analog[i] ? 1'b0 : pin_in[i];      // see RULE3
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pin_out       = state_ff.out;
   assign pin_oe        = state_ff.oe;
   assign pin_in_buf_en = state_ff.buf_en;
   assign port_rd_data  = state_ff.rd;
endmodule : cmc_pin_mux

// >>> cmc_top.sv
// Comparator mode control: configuration, result path and change detection
//
// Functional notes
// RULE1: raw result low when plus below minus
// RULE2: eight modes from three-bit mode field
// RULE3: analog pins: buffer off, port reads zero
// RULE4: output-function pin carries result, overrides port
// RULE5: result pin driven only in 001/011/101
// RULE6: status bit always shows current result
// RULE7: polarity bit inverts status and pin
// RULE8: modes 101/110 switch inverting input
// RULE9: input switch is configuration bit three
// RULE10: mode 000 off, inputs analog, pin I/O
// RULE11: mode 111 off, all three pins I/O
// RULE12: comparator off reads polarity bit value
// RULE13: mode 100 uses reference, no pin drive
// RULE14: software clears direction of driven pin
// RULE15: software sets direction of analog pins
// RULE16: software masks interrupts during mode change
// RULE17: flag set while result differs from latch
// RULE18: register read captures result into latch
// RULE19: reset returns mode field to 000
// RULE20: raw result synchronised before any use
`timescale 1ns/10ps
module cmc_top (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       cfg_wr_en,
   input  wire logic [7:0] cfg_wr_data,
   input  wire logic       cfg_rd_en,
   output logic      [7:0] cfg_rd_data,
   input  wire logic       flag_clear,
   output logic            comparator_change_flag,
   output logic            cmp_result,
   output logic      [2:0] mode_select_field,
   output logic            result_invert,
   output logic            input_switch_sel,
   input  wire logic       cmp_raw,
   output logic            cmp_enable,
   output logic            cmp_ref_sel,
   output logic            cmp_inv_from_noninv_pin,
   input  wire logic [2:0] port_out_data,
   input  wire logic [2:0] pin_direction_bit,
   input  wire logic [2:0] pin_in,
   output logic      [2:0] pin_out,
   output logic      [2:0] pin_oe,
   output logic      [2:0] pin_in_buf_en,
   output logic      [2:0] port_rd_data
);
   import cmc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] mode;       // Mode selection field
      logic       invert;     // Output polarity
      logic       switch_sel; // Inverting input switch
      logic       result;     // Status bit after polarity
      logic       ref_latch;  // Result captured at last access
      logic       flag;       // Sticky change flag
      logic       enable;     // Comparator power to the core
      logic       use_ref;    // Reference on non-inverting input
      logic       inv_swap;   // Inverting input from second pin
   } cmc_state_t;

   cmc_state_t    state_ff;
   cmc_state_t    nxt_state;
   cmc_mode_cfg_t cur_cfg;
   cmc_mode_cfg_t nxt_cfg;
   logic          raw_sync;
   logic          access;
   logic          mismatch;
   logic          wr_invert;
   logic          wr_switch;
   logic    [2:0] wr_mode;

   // ----------------------------------------------------------------
   // Synchroniser for the analog result
   // ----------------------------------------------------------------
   // Core result is asynchronous to the clock
   cmc_sync u_sync (                                    // see RULE20
      .clock    (clock),
      .nrst     (nrst),
      .async_in (cmp_raw),
      .sync_out (raw_sync)
   );

   // ----------------------------------------------------------------
   // Configuration write fields
   // ----------------------------------------------------------------
   // Field extraction from the write data
   assign wr_mode   = cfg_wr_data[CMC_MODE_MSB:CMC_MODE_LSB];  // see RULE2
   assign wr_switch = cfg_wr_data[CMC_SWITCH_BIT];            // see RULE9
   assign wr_invert = cfg_wr_data[CMC_INVERT_BIT];

   // A write counts as an access as it begins with a read
   assign access = cfg_rd_en | cfg_wr_en;

   // Decode of current and next mode
   assign cur_cfg = cmc_decode(state_ff.mode);
   assign nxt_cfg = cmc_decode(cfg_wr_en ? wr_mode : state_ff.mode);

   // Result differs from the value captured at last access
   assign mismatch = state_ff.result ^ state_ff.ref_latch;      // see RULE17

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // Software configuration write
      if (cfg_wr_en) begin
         nxt_state.mode       = wr_mode;                        // see RULE2
         nxt_state.switch_sel = wr_switch;                      // see RULE9
         nxt_state.invert     = wr_invert;
      end

      // Result: raw level (high unless plus input is below minus input) flipped by the polarity bit
      if (cur_cfg.enable) begin
         nxt_state.result = raw_sync ^ state_ff.invert;        // see RULE1 RULE7
      end else begin
         nxt_state.result = state_ff.invert;                   // see RULE12
      end

      // Capture the shown result on any access
      if (access) begin
         nxt_state.ref_latch = state_ff.result;                // see RULE18
      end

      // Mismatch sets the flag; set wins over a clear
      if (mismatch) begin
         nxt_state.flag = 1'b1;                                // see RULE17
      end else if (flag_clear) begin
         nxt_state.flag = 1'b0;
      end

      // Analog core controls follow the mode being entered
      nxt_state.enable   = nxt_cfg.enable;                     // see RULE10
      nxt_state.use_ref  = nxt_cfg.use_ref;                    // see RULE13
      nxt_state.inv_swap = nxt_cfg.mux & nxt_state.switch_sel; // see RULE8
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset puts the block into the reset mode
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff            <= '0;
         state_ff.mode       <= CMC_MODE_RESET;                // see RULE19
         state_ff.invert     <= CMC_BIT_RESET;
         state_ff.switch_sel <= CMC_BIT_RESET;
         state_ff.ref_latch  <= CMC_BIT_RESET;
         state_ff.flag       <= CMC_BIT_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Pin logic
   // ----------------------------------------------------------------
   cmc_pin_if pin_cfg ();

   // Pin functions of the current mode
   assign pin_cfg.analog    = cur_cfg.analog;                  // see RULE3
   assign pin_cfg.drive_cmp = cur_cfg.drive_cmp;               // see RULE5
   assign pin_cfg.cmp_value = state_ff.result;                 // see RULE7
   assign pin_cfg.port_out  = port_out_data;
   assign pin_cfg.port_dir  = pin_direction_bit;               // see RULE14

   cmc_pin_mux u_pins (
      .clock         (clock),
      .nrst          (nrst),
      .pin_cfg       (pin_cfg.pins),
      .pin_in        (pin_in),
      .pin_out       (pin_out),
      .pin_oe        (pin_oe),
      .pin_in_buf_en (pin_in_buf_en),
      .port_rd_data  (port_rd_data)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Configuration read-back, unused bits zero
   always_comb begin
      cfg_rd_data                                = CMC_CFG_RESET;
      cfg_rd_data[CMC_MODE_MSB:CMC_MODE_LSB]     = state_ff.mode;
      cfg_rd_data[CMC_SWITCH_BIT]                = state_ff.switch_sel;
      cfg_rd_data[CMC_INVERT_BIT]                = state_ff.invert;
      cfg_rd_data[CMC_RESULT_BIT]                = state_ff.result;  // see RULE6
   end

   // Register-backed status and core controls
   assign cmp_result              = state_ff.result;           // see RULE6
   assign comparator_change_flag  = state_ff.flag;
   assign mode_select_field       = state_ff.mode;
   assign result_invert           = state_ff.invert;
   assign input_switch_sel        = state_ff.switch_sel;
   assign cmp_enable              = state_ff.enable;           // see RULE11
   assign cmp_ref_sel             = state_ff.use_ref;
   assign cmp_inv_from_noninv_pin = state_ff.inv_swap;

endmodule : cmc_top

// >>> cmc_core_model.sv
// Behavioural analog comparator core and shared pin wiring
`timescale 1ns/10ps
module cmc_core_model (
   input  wire logic        clock,
   input  wire logic        cmp_enable,
   input  wire logic        cmp_ref_sel,
   input  wire logic        cmp_inv_from_noninv_pin,
   input  wire logic [11:0] v_inv,
   input  wire logic [11:0] v_non,
   input  wire logic [11:0] v_ref,
   input  wire logic [2:0]  pin_out,
   input  wire logic [2:0]  pin_oe,
   input  wire logic [2:0]  ext_level,
   output logic             cmp_raw,
   output logic      [2:0]  pin_in
);
   logic [11:0] plus;
   logic [11:0] minus;
   logic        junk = 1'b0;
   // Powered-down core gives a meaningless, toggling level
   always_ff @(posedge clock) begin
      junk <= ~junk;
   end
   // Input selection and comparison
   always_comb begin
      plus = cmp_ref_sel ? v_ref : v_non;
      minus = cmp_inv_from_noninv_pin ? v_non : v_inv;
      cmp_raw = cmp_enable ? (plus >= minus) : junk;
   end
   // Pin level: our driver wins, else the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : cmc_core_model

// >>> cmc_top_asserts.sv
// Port checker for the comparator mode control
`timescale 1ns/10ps
module cmc_asserts (
   input wire logic       clock,
   input wire logic       nrst,
   input wire logic       cfg_wr_en,
   input wire logic [7:0] cfg_wr_data,
   input wire logic       cfg_rd_en,
   input wire logic [7:0] cfg_rd_data,
   input wire logic       flag_clear,
   input wire logic       comparator_change_flag,
   input wire logic       cmp_result,
   input wire logic [2:0] mode_select_field,
   input wire logic       result_invert,
   input wire logic       input_switch_sel,
   input wire logic       cmp_raw,
   input wire logic       cmp_enable,
   input wire logic       cmp_ref_sel,
   input wire logic       cmp_inv_from_noninv_pin,
   input wire logic [2:0] port_out_data,
   input wire logic [2:0] pin_in,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_in_buf_en,
   input wire logic [2:0] port_rd_data
);
   logic [2:0] m;
   logic [2:0] amask;
   logic       drv;
   logic       ref_copy;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Result as captured at the last register access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ref_copy <= 1'b0;
      end else if (cfg_rd_en || cfg_wr_en) begin
         ref_copy <= cmp_result;
      end
   end
   // Mode decode used by the pin checks
   assign m = mode_select_field;
   assign amask = (m == 3'h7) ? 3'h0 : ((m == 3'h3 || m == 3'h4) ? 3'h1 : 3'h3);
   assign drv = (m == 3'h1 || m == 3'h3 || m == 3'h5);
   property p_wr;
      cfg_wr_en |=> m == $past(cfg_wr_data[2:0]) && input_switch_sel == $past(cfg_wr_data[3])
         && result_invert == $past(cfg_wr_data[4]);
   endproperty
   property p_rd;
      cfg_rd_data == {1'b0, cmp_result, 1'b0, result_invert, input_switch_sel, m};
   endproperty
   property p_core;
      cmp_enable == (m != 3'h0 && m != 3'h7) && cmp_ref_sel == (m >= 3'h3 && m <= 3'h6)
         && cmp_inv_from_noninv_pin == ((m == 3'h5 || m == 3'h6) && input_switch_sel);
   endproperty
   property p_path;
      cmp_enable [*4] ##0 $stable(result_invert) |-> cmp_result == ($past(cmp_raw, 3) ^ result_invert);
   endproperty
   property p_off;
      !cmp_enable && !$past(cmp_enable) && $stable(result_invert) |-> cmp_result == result_invert;
   endproperty
   property p_drv;
      drv |=> pin_out[2] == $past(cmp_result);
   endproperty
   property p_io;
      !drv |=> pin_out == $past(port_out_data);
   endproperty
   property p_ana;
      1'b1 |=> pin_in_buf_en == ~$past(amask) && port_rd_data == ($past(pin_in) & ~$past(amask));
   endproperty
   property p_set;
      cmp_result != ref_copy |=> comparator_change_flag;
   endproperty
   property p_clr;
      cfg_rd_en ##1 (flag_clear && $stable(cmp_result)) |=> !comparator_change_flag;
   endproperty
   property p_rst;
      $rose(nrst) |-> m == 3'h0 && !cmp_enable && cfg_rd_data == 8'h00;
   endproperty
   a_wr: assert property (p_wr) else $error("config write not taken");
   a_rd: assert property (p_rd) else $error("readback layout wrong");
   a_core: assert property (p_core) else $error("core controls wrong");
   a_path: assert property (p_path) else $error("result path wrong");
   a_off: assert property (p_off) else $error("off result wrong");
   a_drv: assert property (p_drv) else $error("pin not carrying result");
   a_io: assert property (p_io) else $error("pin not port data");
   a_ana: assert property (p_ana) else $error("analog masking wrong");
   a_set: assert property (p_set) else $error("change flag not set");
   a_clr: assert property (p_clr) else $error("change flag not cleared");
   a_rst: assert property (p_rst) else $error("reset mode wrong");
   c_flag: cover property ($rose(comparator_change_flag));
   c_mux: cover property (cmp_inv_from_noninv_pin);
   c_drv: cover property (m == 3'h5 && pin_out[2]);
endmodule : cmc_asserts
bind cmc_top cmc_asserts i_cmc_asserts (.*);

// >>> cmc_top_tb_top.sv
// Self-checking testbench for the comparator mode control
`timescale 1ns/10ps
module cmc_top_tb_top;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        cfg_wr_en = 1'b0;
   logic [7:0]  cfg_wr_data = 8'h00;
   logic        cfg_rd_en = 1'b0;
   logic        flag_clear = 1'b0;
   logic [2:0]  port_out_data = 3'h0;
   logic [2:0]  pin_direction_bit = 3'h3;
   logic [2:0]  ext_level = 3'h7;
   logic [11:0] v_inv = 12'h190;
   logic [11:0] v_non = 12'h258;
   logic [11:0] v_ref = 12'h320;
   logic [7:0]  cfg_rd_data;
   logic        comparator_change_flag, cmp_result, result_invert, input_switch_sel;
   logic        cmp_raw, cmp_enable, cmp_ref_sel, cmp_inv_from_noninv_pin;
   logic [2:0]  mode_select_field, pin_in, pin_out, pin_oe, pin_in_buf_en, port_rd_data;
   int          n_mismatch = 0;
   int          check_count = 0;
   cmc_top        i_cmc_top (.*);
   cmc_core_model i_cmc_core_model (.*);
   // Free-running clock
   always #5 clock = ~clock;
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task automatic finish_test;
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr_cfg(input logic [7:0] d);
      @(posedge clock);
      cfg_wr_en <= 1'b1;
      cfg_wr_data <= d;
      @(posedge clock);
      cfg_wr_en <= 1'b0;
      tick(5);
   endtask : wr_cfg
   // One-cycle read strobe or flag clear
   task automatic strobe(input logic rd);
      @(posedge clock);
      cfg_rd_en <= rd;
      flag_clear <= ~rd;
      @(posedge clock);
      cfg_rd_en <= 1'b0;
      flag_clear <= 1'b0;
      tick(2);
   endtask : strobe
   // Read strobe, then flag clear on the very next edge
   task automatic rd_clear;
      @(posedge clock);
      cfg_rd_en <= 1'b1;
      @(posedge clock);
      cfg_rd_en <= 1'b0;
      flag_clear <= 1'b1;
      @(posedge clock);
      flag_clear <= 1'b0;
      tick(2);
   endtask : rd_clear
   task automatic set_v(input logic [11:0] n, input logic [11:0] i, input logic [11:0] r);
      @(posedge clock);
      v_non <= n;
      v_inv <= i;
      v_ref <= r;
      tick(5);
   endtask : set_v
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      check("rd_data", 8'h00, cfg_rd_data);
      check("buf_en", 8'h04, {5'h00, pin_in_buf_en});
      check("pin_oe", 8'h04, {5'h00, pin_oe});
   endtask : t_reset
   // Every mode: core power, pin masking, pin override
   task automatic t_modes;
      logic [2:0] am;
      logic       dv;
      logic       en;
      for (int k = 0; k < 8; k++) begin
         am = (k == 7) ? 3'h0 : ((k == 3 || k == 4) ? 3'h1 : 3'h3);
         dv = (k == 1 || k == 3 || k == 5);
         en = (k != 0 && k != 7);
         wr_cfg(8'(k));
         check("rd_data", {1'b0, en, 3'h0, 3'(k)}, cfg_rd_data);
         check("enable", {7'h00, en}, {7'h00, cmp_enable});
         check("buf_en", {5'h00, ~am}, {5'h00, pin_in_buf_en});
         check("port_rd", {5'h00, dv, ~am[1:0]}, {5'h00, port_rd_data});
         check("pin_out", {7'h00, dv}, {7'h00, pin_out[2]});
      end
   endtask : t_modes
   // Polarity on status and pin, and the off-mode value
   task automatic t_polarity;
      logic [7:0] offs [3] = '{8'h10, 8'h17, 8'h07};
      port_out_data <= 3'h7;
      for (int k = 0; k < 4; k++) begin
         set_v(k[1] ? 12'h258 : 12'h0C8, 12'h190, 12'h320);
         wr_cfg({3'h0, k[0], 4'h1});
         check("status", {7'h00, k[1] ^ k[0]}, {7'h00, cmp_result});
         check("pin_out", {7'h00, k[1] ^ k[0]}, {7'h00, pin_out[2]});
      end
      foreach (offs[k]) begin
         wr_cfg(offs[k]);
         check("off_res", {7'h00, offs[k][4]}, {7'h00, cmp_result});
      end
      port_out_data <= 3'h0;
   endtask : t_polarity
   // Input switch in both multiplexed modes
   task automatic t_switch;
      set_v(12'h258, 12'h0C8, 12'h190);
      for (int k = 0; k < 4; k++) begin
         wr_cfg({4'h0, k[0], 1'b1, k[1], ~k[1]});
         check("swap", {7'h00, k[0]}, {7'h00, cmp_inv_from_noninv_pin});
         check("status", {7'h00, ~k[0]}, {7'h00, cmp_result});
         check("buf_en", 8'h04, {5'h00, pin_in_buf_en});
      end
   endtask : t_switch
   // Change flag against the reference latch
   task automatic t_flag;
      set_v(12'h258, 12'h190, 12'h320);
      wr_cfg(8'h02);
      strobe(1'b1);
      strobe(1'b0);
      check("flag", 8'h00, {7'h00, comparator_change_flag});
      set_v(12'h0C8, 12'h190, 12'h320);
      check("flag", 8'h01, {7'h00, comparator_change_flag});
      strobe(1'b0);
      check("flag", 8'h01, {7'h00, comparator_change_flag});
      strobe(1'b1);
      strobe(1'b0);
      check("flag", 8'h00, {7'h00, comparator_change_flag});
      set_v(12'h258, 12'h190, 12'h320);
      check("flag", 8'h01, {7'h00, comparator_change_flag});
      rd_clear;
      check("flag", 8'h00, {7'h00, comparator_change_flag});
   endtask : t_flag
   // Reset in mid-run returns the reset mode
   task automatic t_midreset;
      wr_cfg(8'h1D);
      @(posedge clock);
      nrst <= 1'b0;
      tick(2);
      check("mode", 8'h00, cfg_rd_data);
      @(posedge clock);
      nrst <= 1'b1;
      tick(2);
   endtask : t_midreset
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      tick(2);
      t_reset;
      t_modes;
      t_polarity;
      t_switch;
      t_flag;
      t_midreset;
      finish_test;
   end
   // Watchdog against a hang
   initial begin
      repeat (3000) @(posedge clock);
      n_mismatch++;
      finish_test;
   end
endmodule : cmc_top_tb_top
